// file: core/cfg_pkg.sv
package cfg_pkg;

  // Register indexes; byte address is four times the index
  localparam logic [5:0] IDX_RECV_CTRL   = 6'h00;
  localparam logic [5:0] IDX_GAIN_CTRL   = 6'h04;
  localparam logic [5:0] IDX_VSB_LOW     = 6'h1B;
  localparam logic [5:0] IDX_VSB_MID     = 6'h1C;
  localparam logic [5:0] IDX_VSB_HIGH    = 6'h1D;
  localparam logic [5:0] IDX_QAM_LOW     = 6'h1E;
  localparam logic [5:0] IDX_QAM_MID     = 6'h1F;
  localparam logic [5:0] IDX_QAM_HIGH    = 6'h20;
  localparam logic [5:0] IDX_THRESH_LOW  = 6'h21;
  localparam logic [5:0] IDX_THRESH_HIGH = 6'h22;
  localparam logic [5:0] IDX_RECV_STATUS = 6'h26;

  // Field positions
  localparam int GAIN_INVERT_BIT = 2;
  localparam int OVER_THRESH_BIT = 3;

  // Values after reset
  localparam logic [1:0] RST_DEMOD_SEL   = 2'h0;
  localparam logic [2:0] RST_GAIN_CTRL   = 3'h7;
  localparam logic [7:0] RST_VSB_LOW     = 8'hBC;
  localparam logic [7:0] RST_VSB_MID     = 8'h64;
  localparam logic [7:0] RST_VSB_HIGH    = 8'h00;
  localparam logic [7:0] RST_QAM_LOW     = 8'h00;
  localparam logic [7:0] RST_QAM_MID     = 8'h08;
  localparam logic [7:0] RST_QAM_HIGH    = 8'h00;
  localparam logic [7:0] RST_THRESH_LOW  = 8'h05;
  localparam logic [3:0] RST_THRESH_HIGH = 4'h0;

  localparam int INTERVAL_WIDTH  = 24;
  localparam int THRESHOLD_WIDTH = 12;

  typedef enum logic [1:0] {
    DEMOD_VSB8   = 2'b00,
    DEMOD_RSVD   = 2'b01,
    DEMOD_QAM64  = 2'b10,
    DEMOD_QAM256 = 2'b11
  } demod_sel_t;

endpackage

// file: core/interval_if.sv
`timescale 1ns/1ps
`default_nettype none
interface interval_if #(
  parameter int IW = 24,
  parameter int TW = 12
);
  logic [IW-1:0] interval;
  logic [TW-1:0] threshold;
  logic          restart;
  logic          block_done;
  logic          seg_error;
  logic          over_threshold;
  logic          interval_done;

  modport ctrl (
    output interval, threshold, restart, block_done, seg_error,
    input  over_threshold, interval_done
  );
  modport mon (
    input  interval, threshold, restart, block_done, seg_error,
    output over_threshold, interval_done
  );
endinterface
`default_nettype wire

// file: core/interval_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module interval_monitor #(
  parameter int IW = 24,
  parameter int TW = 12
) (
  input  wire logic ref_clk_i,
  input  wire logic rstn_i,
  interval_if.mon   mon
);
  import cfg_pkg::*;

  logic [IW-1:0] block_cnt_reg;
  logic [TW:0]   err_cnt_reg;
  logic          over_reg;
  logic          done_reg;

  wire [IW-1:0] block_cnt_inc = block_cnt_reg + 1'b1;
  // Zero interval closes on every block rather than never
  wire          at_end = mon.block_done && (block_cnt_inc >= mon.interval);
  // One extra bit saturates so a long burst never wraps below threshold
  wire          err_sat = &err_cnt_reg;
  wire [TW:0]   err_total = (mon.seg_error && !err_sat) ?
                            err_cnt_reg + 1'b1 : err_cnt_reg;

  assign mon.over_threshold = over_reg;
  assign mon.interval_done  = done_reg;

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      block_cnt_reg <= '0;
      err_cnt_reg   <= '0;
      over_reg      <= 1'b0;
      done_reg      <= 1'b0;
    end else if (mon.restart) begin
      block_cnt_reg <= '0;
      err_cnt_reg   <= '0;
      over_reg      <= 1'b0;
      done_reg      <= 1'b0;
    end else begin
      done_reg <= at_end;
      if (at_end) begin
        block_cnt_reg <= '0;
        err_cnt_reg   <= '0;
        over_reg      <= (err_total > {1'b0, mon.threshold});
      end else begin
        if (mon.block_done)
          block_cnt_reg <= block_cnt_inc;
        err_cnt_reg <= err_total;
      end
    end
  end
endmodule
`default_nettype wire

// file: core/agc_fec_cfg.sv
// Functional notes
// - Gain and interval settings take effect only at the next soft reset.
// - A write to register 00h starts a soft reset that applies settings.
// - Gain control bit 2 at 1 inverts the gain output and is 1 after reset.
// - VSB interval bits 23:0 come from bytes 1Dh, 1Ch, 1Bh, high to low.
// - QAM interval bits 23:0 come from bytes 20h, 1Fh, 1Eh, high to low.
// - An interval counts decoded blocks; errors accumulate over that many.
// - Demod select 00 is VSB, 1x QAM, 01 reserved; 00 and 01 use the VSB interval, 1x the QAM one.
// - Status is 1 when an interval's errors exceed the 12-bit threshold.
`timescale 1ns/1ps
`default_nettype none
module agc_fec_cfg #(
  parameter int INTERVAL_W  = cfg_pkg::INTERVAL_WIDTH,
  parameter int THRESHOLD_W = cfg_pkg::THRESHOLD_WIDTH
) (
  input  wire logic        ref_clk_i,
  input  wire logic        rstn_i,
  input  wire logic [7:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic        gain_ctrl_raw_i,
  input  wire logic        rs_block_done_i,
  input  wire logic        segment_error_i,
  output logic             gain_control_output_o,
  output logic      [1:0]  demod_type_select_o,
  output logic             soft_reset_o,
  output logic             interval_done_o,
  output logic             segment_error_over_threshold_o
);
  import cfg_pkg::*;

  if (INTERVAL_W != 24 || THRESHOLD_W != 12) begin : g_check
    $error("Register map serves only 24-bit intervals, 12-bit threshold");
  end

  // Shadow registers written by software
  logic [1:0]  demod_sel_reg;
  logic [2:0]  gain_ctrl_reg;
  logic [7:0]  vsb_byte_reg [3];
  logic [7:0]  qam_byte_reg [3];
  logic [7:0]  thresh_low_reg;
  logic [3:0]  thresh_high_reg;

  // Working copies taken at soft reset
  logic                   act_invert_reg;
  logic [1:0]             act_demod_reg;
  logic [INTERVAL_W-1:0]  act_vsb_reg;
  logic [INTERVAL_W-1:0]  act_qam_reg;
  logic [THRESHOLD_W-1:0] act_thresh_reg;

  logic        soft_rst_reg;
  logic        wait_reg;
  logic [31:0] rdata_reg;
  logic        gain_out_reg;
  logic        blk_reg;
  logic        err_reg;

  interval_if #(.IW(INTERVAL_W), .TW(THRESHOLD_W)) ivl ();

  // Bus handshake: waitrequest drops one cycle after a request appears
  wire       req      = avs_read_i || avs_write_i;
  wire       accept   = req && !wait_reg;
  wire       wr_fire  = accept && avs_write_i && avs_byteenable_i[0];
  wire [5:0] idx      = avs_address_i[7:2];
  wire [7:0] wbyte    = avs_writedata_i[7:0];

  function automatic logic hit(input logic [5:0] a, input logic [5:0] b);
    return a == b;
  endfunction

  wire [INTERVAL_W-1:0] vsb_word = {vsb_byte_reg[2], vsb_byte_reg[1],
                                    vsb_byte_reg[0]};
  wire [INTERVAL_W-1:0] qam_word = {qam_byte_reg[2], qam_byte_reg[1],
                                    qam_byte_reg[0]};

  logic [7:0] rbyte;
  always_comb begin
    rbyte = 8'h00;
    if (hit(idx, IDX_RECV_CTRL))
      rbyte = {6'h00, demod_sel_reg};
    else if (hit(idx, IDX_GAIN_CTRL))
      rbyte = {5'h00, gain_ctrl_reg};
    else if (hit(idx, IDX_VSB_LOW))
      rbyte = vsb_byte_reg[0];
    else if (hit(idx, IDX_VSB_MID))
      rbyte = vsb_byte_reg[1];
    else if (hit(idx, IDX_VSB_HIGH))
      rbyte = vsb_byte_reg[2];
    else if (hit(idx, IDX_QAM_LOW))
      rbyte = qam_byte_reg[0];
    else if (hit(idx, IDX_QAM_MID))
      rbyte = qam_byte_reg[1];
    else if (hit(idx, IDX_QAM_HIGH))
      rbyte = qam_byte_reg[2];
    else if (hit(idx, IDX_THRESH_LOW))
      rbyte = thresh_low_reg;
    else if (hit(idx, IDX_THRESH_HIGH))
      rbyte = {4'h0, thresh_high_reg};
    else if (hit(idx, IDX_RECV_STATUS))
      rbyte = {4'h0, ivl.over_threshold, 3'h0};
  end

  // Reserved select 01 falls back to the VSB count
  wire use_qam = act_demod_reg[1];

  assign ivl.interval   = use_qam ? act_qam_reg : act_vsb_reg;
  assign ivl.threshold  = act_thresh_reg;
  assign ivl.restart    = soft_rst_reg;
  assign ivl.block_done = blk_reg;
  assign ivl.seg_error  = err_reg;

  interval_monitor #(.IW(INTERVAL_W), .TW(THRESHOLD_W)) u_monitor (
    .ref_clk_i (ref_clk_i),
    .rstn_i    (rstn_i),
    .mon       (ivl.mon)
  );

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wait_reg  <= 1'b1;
      rdata_reg <= 32'h0000_0000;
    end else begin
      wait_reg <= !(req && wait_reg);
      if (req && wait_reg)
        rdata_reg <= {24'h00_0000, rbyte};
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      demod_sel_reg   <= RST_DEMOD_SEL;
      gain_ctrl_reg   <= RST_GAIN_CTRL;
      vsb_byte_reg[0] <= RST_VSB_LOW;
      vsb_byte_reg[1] <= RST_VSB_MID;
      vsb_byte_reg[2] <= RST_VSB_HIGH;
      qam_byte_reg[0] <= RST_QAM_LOW;
      qam_byte_reg[1] <= RST_QAM_MID;
      qam_byte_reg[2] <= RST_QAM_HIGH;
      thresh_low_reg  <= RST_THRESH_LOW;
      thresh_high_reg <= RST_THRESH_HIGH;
    end else if (wr_fire) begin
      if (hit(idx, IDX_RECV_CTRL))
        demod_sel_reg <= wbyte[1:0];
      else if (hit(idx, IDX_GAIN_CTRL))
        gain_ctrl_reg <= wbyte[2:0];
      else if (hit(idx, IDX_VSB_LOW))
        vsb_byte_reg[0] <= wbyte;
      else if (hit(idx, IDX_VSB_MID))
        vsb_byte_reg[1] <= wbyte;
      else if (hit(idx, IDX_VSB_HIGH))
        vsb_byte_reg[2] <= wbyte;
      else if (hit(idx, IDX_QAM_LOW))
        qam_byte_reg[0] <= wbyte;
      else if (hit(idx, IDX_QAM_MID))
        qam_byte_reg[1] <= wbyte;
      else if (hit(idx, IDX_QAM_HIGH))
        qam_byte_reg[2] <= wbyte;
      else if (hit(idx, IDX_THRESH_LOW))
        thresh_low_reg <= wbyte;
      else if (hit(idx, IDX_THRESH_HIGH))
        thresh_high_reg <= wbyte[3:0];
    end
  end

  // Any byte lane counts: the write itself is the trigger
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i)
      soft_rst_reg <= 1'b0;
    else
      soft_rst_reg <= accept && avs_write_i &&
                      hit(idx, IDX_RECV_CTRL);
  end

  // Settings move into use only on the soft reset pulse
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      act_invert_reg <= RST_GAIN_CTRL[GAIN_INVERT_BIT];
      act_demod_reg  <= RST_DEMOD_SEL;
      act_vsb_reg    <= {RST_VSB_HIGH, RST_VSB_MID, RST_VSB_LOW};
      act_qam_reg    <= {RST_QAM_HIGH, RST_QAM_MID, RST_QAM_LOW};
      act_thresh_reg <= {RST_THRESH_HIGH, RST_THRESH_LOW};
    end else if (soft_rst_reg) begin
      act_invert_reg <= gain_ctrl_reg[GAIN_INVERT_BIT];
      act_demod_reg  <= demod_sel_reg;
      act_vsb_reg    <= vsb_word;
      act_qam_reg    <= qam_word;
      act_thresh_reg <= {thresh_high_reg, thresh_low_reg};
    end
  end

  // Inputs registered once so every path starts from a flop
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      gain_out_reg <= 1'b0;
      blk_reg      <= 1'b0;
      err_reg      <= 1'b0;
    end else begin
      gain_out_reg <= gain_ctrl_raw_i ^ act_invert_reg;
      blk_reg      <= rs_block_done_i;
      err_reg      <= segment_error_i;
    end
  end

  assign avs_readdata_o                 = rdata_reg;
  assign avs_waitrequest_o              = wait_reg;
  assign gain_control_output_o          = gain_out_reg;
  assign demod_type_select_o            = act_demod_reg;
  assign soft_reset_o                   = soft_rst_reg;
  assign interval_done_o                = ivl.interval_done;
  assign segment_error_over_threshold_o = ivl.over_threshold;

endmodule
`default_nettype wire

// file: tb/agc_fec_cfg_props.sv
`timescale 1ns/1ps
`default_nettype none
module agc_fec_cfg_props
  import cfg_pkg::*;
(
  input wire logic        ref_clk_i,
  input wire logic        rstn_i,
  input wire logic [7:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0]  avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  input wire logic        gain_ctrl_raw_i,
  input wire logic        rs_block_done_i,
  input wire logic        segment_error_i,
  input wire logic        gain_control_output_o,
  input wire logic [1:0]  demod_type_select_o,
  input wire logic        soft_reset_o,
  input wire logic        interval_done_o,
  input wire logic        segment_error_over_threshold_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  logic st_inv;
  logic act_inv;
  wire  wr_done = avs_write_i && !avs_waitrequest_o;
  wire  rd_done = avs_read_i && !avs_waitrequest_o;
  wire  wr_ctrl = wr_done && avs_address_i[7:2] == IDX_RECV_CTRL;
  wire  wr_gain = wr_done && avs_address_i[7:2] == IDX_GAIN_CTRL;
  // Shadow of the invert bit; only a soft reset makes it live
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_inv  <= 1'h1;
      act_inv <= 1'h1;
    end else begin
      if (wr_gain && avs_byteenable_i[0])
        st_inv <= avs_writedata_i[GAIN_INVERT_BIT];
      if (soft_reset_o)
        act_inv <= st_inv;
    end
  end
  wait_low_a: assert property ((avs_read_i || avs_write_i) &&
    avs_waitrequest_o |=> !avs_waitrequest_o) else $error("no answer");
  wait_pulse_a: assert property (!avs_waitrequest_o |=>
    avs_waitrequest_o) else $error("wait low too long");
  soft_start_a: assert property (wr_ctrl |=> soft_reset_o)
    else $error("soft reset missing");
  soft_cause_a: assert property (soft_reset_o |-> $past(wr_ctrl))
    else $error("soft reset unprompted");
  // Two cycles of slack around the load edge of the live setting
  gain_pol_a: assert property ($past(rstn_i) &&
    !$past(soft_reset_o) && !$past(soft_reset_o, 2) |->
    gain_control_output_o == ($past(gain_ctrl_raw_i) ^ act_inv))
    else $error("gain polarity wrong");
  demod_hold_a: assert property (!$stable(demod_type_select_o) |->
    $past(soft_reset_o)) else $error("demod changed early");
  done_cause_a: assert property (interval_done_o |->
    $past(rs_block_done_i, 2)) else $error("done without block");
  over_hold_a: assert property (!$stable(segment_error_over_threshold_o)
    |-> interval_done_o || soft_reset_o || $past(soft_reset_o))
    else $error("status changed mid interval");
  rsvd_zero_a: assert property (rd_done &&
    avs_address_i[7:2] == IDX_GAIN_CTRL |-> avs_readdata_o[7:3] == 5'h00)
    else $error("reserved bits set");
endmodule
bind agc_fec_cfg agc_fec_cfg_props agc_fec_cfg_props_inst (.*);
`default_nettype wire

// file: tb/agc_fec_cfg_bench.sv
`timescale 1ns/1ps
`default_nettype none
module agc_fec_cfg_bench;
  import cfg_pkg::*;
  logic        ref_clk_i = 1'h0;
  logic        rstn_i = 1'h0;
  logic        avs_read_i = 1'h0;
  logic        avs_write_i = 1'h0;
  logic        gain_ctrl_raw_i = 1'h0;
  logic        rs_block_done_i = 1'h0;
  logic        segment_error_i = 1'h0;
  logic [7:0]  avs_address_i = 8'h00;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0]  avs_byteenable_i = 4'hF;
  wire  [31:0] avs_readdata_o;
  wire         avs_waitrequest_o;
  wire         gain_control_output_o;
  wire  [1:0]  demod_type_select_o;
  wire         soft_reset_o;
  wire         interval_done_o;
  wire         segment_error_over_threshold_o;
  int          n_fail, n_checks, cyc, n_done, n_soft, k, d0;
  logic [7:0]  rst_v [6] = '{8'hBC, 8'h64, 8'h00, 8'h00, 8'h08, 8'h00};
  logic [7:0]  new_v [6] = '{8'h03, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00};
  logic [1:0]  md [4] = '{2'h0, 2'h2, 2'h3, 2'h1};
  int          ni [4] = '{3, 2, 2, 3};

  agc_fec_cfg agc_fec_cfg_inst (.*);

  initial forever #2 ref_clk_i = ~ref_clk_i;

  always @(posedge ref_clk_i) begin
    cyc++;
    if (interval_done_o === 1'h1) n_done++;
    if (soft_reset_o === 1'h1) n_soft++;
    if (cyc == 5000) begin
      n_fail++;
      finish_test();
    end
  end

  task automatic finish_test();
    if (n_fail == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Idle gap after each access so no signal is driven twice in a step
  task automatic bus(input logic w, input logic [5:0] idx,
                     input logic [7:0] d, output logic [31:0] q);
    avs_address_i   <= {idx, 2'h0};
    avs_writedata_i <= {24'h0, d};
    avs_write_i     <= w;
    avs_read_i      <= !w;
    do @(posedge ref_clk_i); while (avs_waitrequest_o !== 1'h0);
    q = avs_readdata_o;
    avs_write_i <= 1'h0;
    avs_read_i  <= 1'h0;
    repeat (2) @(posedge ref_clk_i);
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    logic [31:0] q;
    bus(1'h1, idx, d, q);
  endtask

  task automatic rd(input logic [5:0] idx, input logic [31:0] e, string s);
    logic [31:0] q;
    bus(1'h0, idx, 8'h00, q);
    check(s, q, e);
  endtask

  task automatic blk(input logic err);
    rs_block_done_i <= 1'h1;
    segment_error_i <= err;
    @(posedge ref_clk_i);
    rs_block_done_i <= 1'h0;
    segment_error_i <= 1'h0;
    repeat (3) @(posedge ref_clk_i);
  endtask

  initial begin
    repeat (16) @(posedge ref_clk_i);
    rstn_i <= 1'h1;
    @(posedge ref_clk_i);
    rd(IDX_GAIN_CTRL, 32'h07, "gain reset");
    for (int i = 0; i < 6; i++) begin
      rd(IDX_VSB_LOW + 6'(i), {24'h0, rst_v[i]}, "interval reset");
      wr(IDX_VSB_LOW + 6'(i), new_v[i]);
      rd(IDX_VSB_LOW + 6'(i), {24'h0, new_v[i]}, "interval rw");
    end
    rd(6'h3F, 32'h0, "unmapped");
    wr(IDX_THRESH_LOW, 8'h01);
    wr(IDX_THRESH_HIGH, 8'h00);
    wr(IDX_GAIN_CTRL, 8'hFB);
    rd(IDX_GAIN_CTRL, 32'h03, "gain rsvd");
    gain_ctrl_raw_i <= 1'h1;
    repeat (3) @(posedge ref_clk_i);
    check("gain before soft", gain_control_output_o, 1'h0);
    for (int m = 0; m < 4; m++) begin
      d0 = n_soft;
      wr(IDX_RECV_CTRL, {6'h00, md[m]});
      check("soft pulses", n_soft - d0, 1);
      check("demod", demod_type_select_o, md[m]);
      // Output flop takes the new polarity one edge after the load
      @(posedge ref_clk_i);
      check("gain after soft", gain_control_output_o, 1'h1);
      d0 = n_done;
      k = 0;
      while (n_done == d0 && k < 6) begin
        blk(1'h1);
        k++;
      end
      check("blocks", k, ni[m]);
      check("over", segment_error_over_threshold_o, 1'h1);
      rd(IDX_RECV_STATUS, 32'h08, "status");
    end
    blk(1'h1);
    blk(1'h0);
    blk(1'h0);
    check("over cleared", segment_error_over_threshold_o, 1'h0);
    rd(IDX_RECV_STATUS, 32'h00, "status clear");
    finish_test();
  end
endmodule
`default_nettype wire
